// file: hw/jlsync_ctrl.sv
`timescale 1ns/100ps
`include "jlsync_defines.svh"
// Overview of operation
// [R1] In 8B/10B mode with source select 0 the active-low single-ended sync pin starts link initialisation.
// [R2] A low sync level in 8B/10B mode starts code group synchronisation on the lanes.
// [R3] The initial lane alignment sequence starts only once sync returns high after code group sync.
// [R4] In 64B/66B mode sync never initialises the link and only yields an oscillator sync trigger.
// [R5] With source select 1 the sync request comes from the differential timestamp pair.
// [R6] Lane alignment starts are aligned to a sysref rising edge for deterministic latency.
// [R7] The selected sync source passes a three-flop synchroniser before its level is used.
module jlsync_ctrl
  import jlsync_pkg::*;
#(
  // Synchroniser depth; the agreement filter needs at least three stages
  parameter int SYNC_STAGES = `JLSYNC_SYNC_STAGES
)
(
  // Clock and reset
  input  wire logic           i_clk_sys,
  input  wire logic           i_nrst,
  // Configuration
  input  wire logic           i_sync_src_sel,
  input  wire logic           i_enc_mode,
  // Pins
  input  wire logic           i_single_ended_link_sync_input_n,
  input  wire logic           i_timestamp_diff_pair,
  input  wire logic           i_sysref,
  // Lane control
  input  wire logic           i_cgs_done,
  output jlsync_status_t      o_status,
  output jlsync_state_t       o_state
);

  // =====================================================================
  // Elaboration checks
  // [R7] The filter compares the last two stages behind a capture stage
  generate
    if (SYNC_STAGES < 3)
    begin : g_depth_check
      $error("SYNC_STAGES must be at least 3");
    end
  endgenerate

  // =====================================================================
  // Helper functions

  // Level after the agreement filter: follows the last stage only when the one before matches
  function automatic logic settle_level
  (
    input logic stage_mid,
    input logic stage_last,
    input logic held
  );
    settle_level = (stage_mid == stage_last) ? stage_last : held;
  endfunction

  // Rising edge of a filtered level
  function automatic logic rise_of
  (
    input logic prev,
    input logic curr
  );
    rise_of = curr & ~prev;
  endfunction

  // Falling edge of a filtered level
  function automatic logic fall_of
  (
    input logic prev,
    input logic curr
  );
    fall_of = prev & ~curr;
  endfunction

  // =====================================================================
  // Source selection and synchronisers
  logic                       sync_raw;
  logic [SYNC_STAGES-1:0]     sync_reg;
  logic [SYNC_STAGES-1:0]     sync_next;
  logic [SYNC_STAGES-1:0]     sref_reg;
  logic [SYNC_STAGES-1:0]     sref_next;
  logic                       sync_lvl_reg;
  logic                       sync_lvl_next;
  logic                       sref_lvl_reg;
  logic                       sref_lvl_next;

  // [R5] Source select mux
  always_comb
  begin
    sync_raw = (i_sync_src_sel == `JLSYNC_SRC_TSTAMP) ? i_timestamp_diff_pair
                                                       : i_single_ended_link_sync_input_n;
  end

  // [R7] Sync filter: shift, then move the level once two stages agree
  always_comb
  begin
    sync_next     = {sync_reg[SYNC_STAGES-2:0], sync_raw};
    sync_lvl_next = settle_level(sync_reg[SYNC_STAGES-2], sync_reg[SYNC_STAGES-1], sync_lvl_reg);
  end

  // Idle level high, so reset never looks like a request
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      sync_reg     <= {SYNC_STAGES{`JLSYNC_SYNC_RST}};
      sync_lvl_reg <= `JLSYNC_SYNC_RST;
    end
    else
    begin
      sync_reg     <= sync_next;
      sync_lvl_reg <= sync_lvl_next;
    end
  end

  // [R6] Sysref filter, same depth so both references see equal latency
  always_comb
  begin
    sref_next     = {sref_reg[SYNC_STAGES-2:0], i_sysref};
    sref_lvl_next = settle_level(sref_reg[SYNC_STAGES-2], sref_reg[SYNC_STAGES-1], sref_lvl_reg);
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      sref_reg     <= {SYNC_STAGES{`JLSYNC_SREF_RST}};
      sref_lvl_reg <= `JLSYNC_SREF_RST;
    end
    else
    begin
      sref_reg     <= sref_next;
      sref_lvl_reg <= sref_lvl_next;
    end
  end

  // =====================================================================
  // Edge detection on the filtered levels
  logic                       sync_prev_reg;
  logic                       sync_prev_next;
  logic                       sref_prev_reg;
  logic                       sref_prev_next;
  logic                       sref_edge;
  logic                       sync_fall;

  always_comb
  begin
    sync_prev_next = sync_lvl_reg;
    sref_prev_next = sref_lvl_reg;
    sref_edge      = rise_of(sref_prev_reg, sref_lvl_reg);
    sync_fall      = fall_of(sync_prev_reg, sync_lvl_reg);
  end

  // Reset to idle levels so no false edge follows reset
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      sync_prev_reg <= `JLSYNC_SYNC_RST;
      sref_prev_reg <= `JLSYNC_SREF_RST;
    end
    else
    begin
      sync_prev_reg <= sync_prev_next;
      sref_prev_reg <= sref_prev_next;
    end
  end

  // =====================================================================
  // Link initialisation sequencer
  jlsync_state_t              state_reg;
  jlsync_state_t              state_next;
  jlsync_status_t             status_reg;
  jlsync_status_t             status_next;
  logic                       is_8b10b;

  always_comb
  begin
    is_8b10b    = (i_enc_mode == `JLSYNC_ENC_8B10B);
    state_next  = state_reg;
    status_next = '0;
    unique case (state_reg)
      JLSYNC_ST_IDLE:
      begin
        // [R1] [R2] Low level requests sync
        if (is_8b10b && !sync_lvl_reg)
          state_next = JLSYNC_ST_CGS;
      end
      JLSYNC_ST_CGS:
      begin
        // [R3] Wait for release after sync
        if (sync_lvl_reg && i_cgs_done)
          state_next = JLSYNC_ST_WAIT;
      end
      JLSYNC_ST_WAIT:
      begin
        // [R6] Align to sysref edge
        if (!sync_lvl_reg)
          state_next = JLSYNC_ST_CGS;
        else if (sref_edge)
        begin
          state_next             = JLSYNC_ST_ILAS;
          status_next.ilas_start = 1'b1;
        end
      end
      JLSYNC_ST_ILAS:
      begin
        if (!sync_lvl_reg)
          state_next = JLSYNC_ST_CGS;
      end
    endcase
    // [R4] 64B/66B ignores sync for init
    if (!is_8b10b)
    begin
      state_next             = JLSYNC_ST_IDLE;
      status_next.ilas_start = 1'b0;
      status_next.nco_sync_pulse = sync_fall;
    end
    status_next.cgs_active  = (state_next == JLSYNC_ST_CGS) || (state_next == JLSYNC_ST_WAIT);
    status_next.ilas_active = (state_next == JLSYNC_ST_ILAS);
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      state_reg     <= JLSYNC_ST_IDLE;
      status_reg    <= '0;
    end
    else
    begin
      state_reg     <= state_next;
      status_reg    <= status_next;
    end
  end

  assign o_status = status_reg;
  assign o_state  = state_reg;

endmodule // jlsync_ctrl

// file: hw/jlsync_defines.svh
`ifndef JLSYNC_DEFINES_SVH
`define JLSYNC_DEFINES_SVH

// =====================================================================
// Source selection and encoding codes
`define JLSYNC_SRC_SINGLE   1'h0
`define JLSYNC_SRC_TSTAMP   1'h1
`define JLSYNC_ENC_8B10B    1'h0
`define JLSYNC_ENC_64B66B   1'h1

// =====================================================================
// Synchroniser depth and reset level of the sync request (idle high)
`define JLSYNC_SYNC_STAGES  3
`define JLSYNC_SYNC_RST     1'h1
`define JLSYNC_SREF_RST     1'h0

`endif

// file: hw/jlsync_pkg.sv
package jlsync_pkg;

  typedef enum logic [1:0]
  {
    JLSYNC_ST_IDLE = 2'b00,
    JLSYNC_ST_CGS  = 2'b01,
    JLSYNC_ST_WAIT = 2'b10,
    JLSYNC_ST_ILAS = 2'b11
  } jlsync_state_t;

  typedef struct packed
  {
    logic cgs_active;
    logic ilas_start;
    logic ilas_active;
    logic nco_sync_pulse;
  } jlsync_status_t;

endpackage

// file: sim/jlsync_ctrl_chk.sv
`timescale 1ns/100ps
module jlsync_ctrl_chk
  import jlsync_pkg::*;
(
  input wire logic i_clk_sys, i_nrst, i_sync_src_sel, i_enc_mode, i_sysref, i_timestamp_diff_pair,
  input wire logic i_single_ended_link_sync_input_n,
  input wire jlsync_status_t o_status,
  input wire jlsync_state_t o_state
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  wire se = !i_enc_mode && !i_sync_src_sel && !i_single_ended_link_sync_input_n;
  wire tp = !i_enc_mode && i_sync_src_sel && !i_timestamp_diff_pair;
  property p_se; se[*6] |-> o_state == JLSYNC_ST_CGS; endproperty
  a_se: assert property (p_se) else $error("se");
  property p_tp; tp[*6] |-> o_state == JLSYNC_ST_CGS; endproperty
  a_tp: assert property (p_tp) else $error("tp");
  property p_64; i_enc_mode[*2] |-> o_state == JLSYNC_ST_IDLE; endproperty
  a_64: assert property (p_64) else $error("64");
  property p_il; o_status.ilas_start |-> $past(o_state) == JLSYNC_ST_WAIT; endproperty
  a_il: assert property (p_il) else $error("il");
  property p_sr; o_status.ilas_start |-> $past(i_sysref, 4); endproperty
  a_sr: assert property (p_sr) else $error("sr");
  property p_fl; $fell(i_single_ended_link_sync_input_n) && se && o_state != JLSYNC_ST_CGS
    |-> ##2 o_state != JLSYNC_ST_CGS; endproperty
  a_fl: assert property (p_fl) else $error("fl");
  property p_ca; o_status.cgs_active == (o_state inside {JLSYNC_ST_CGS, JLSYNC_ST_WAIT}); endproperty
  a_ca: assert property (p_ca) else $error("ca");
endmodule // jlsync_ctrl_chk
bind jlsync_ctrl jlsync_ctrl_chk u_chk (.*);

// file: sim/jlsync_ctrl_tb_top.sv
`timescale 1ns/100ps
module jlsync_ctrl_tb_top;
  import jlsync_pkg::*;
  logic i_clk_sys = 1'h0, i_nrst, i_sync_src_sel, i_enc_mode, i_timestamp_diff_pair, i_cgs_done, i_sysref;
  logic req, i_single_ended_link_sync_input_n;
  jlsync_status_t o_status;
  jlsync_state_t  o_state;
  int errors = 0, comparisons = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  jlsync_rx_model u_rx (.i_clk_sys, .i_req(req), .i_cgs_active(o_status.cgs_active),
    .o_sync_n(i_single_ended_link_sync_input_n));
  jlsync_ctrl u_dut (.*);
  task chk(input logic [3:0] a, b);
    comparisons++;
    if (a !== b) $display("Error %0t value %h not %h", $time, a, b);
    errors += int'(a !== b);
  endtask
  task ws(input jlsync_state_t s);
    for (int k = 0; k < 40 && o_state !== s; k++) @(posedge i_clk_sys);
    chk(o_state, s);
  endtask
  task rst(input logic [5:0] cfg);
    {i_nrst, i_sync_src_sel, i_enc_mode, i_timestamp_diff_pair, req, i_cgs_done, i_sysref} <= {1'h0, cfg};
    repeat (4) @(posedge i_clk_sys);
    i_nrst <= 1'h1;
  endtask
  task t_link();
    req <= 1'h1;
    ws(JLSYNC_ST_CGS);
    chk(o_status, 4'h8);
    i_cgs_done <= 1'h1;
    ws(JLSYNC_ST_WAIT);
    chk(o_status, 4'h8);
    i_sysref <= 1'h1;
    ws(JLSYNC_ST_ILAS);
    chk(o_status, 4'h6);
    @(posedge i_clk_sys);
    chk(o_status, 4'h2);
    req <= 1'h0;
    @(posedge i_clk_sys);
    req <= 1'h1;
    ws(JLSYNC_ST_CGS);
  endtask
  task t_src();
    rst(6'h18);
    req <= 1'h1;
    for (int k = 0; k < 20 && o_status.nco_sync_pulse !== 1'h1; k++) @(posedge i_clk_sys);
    chk(o_status, 4'h1);
    @(posedge i_clk_sys);
    chk(o_status, 4'h0);
    repeat (9) @(posedge i_clk_sys);
    chk(o_state, JLSYNC_ST_IDLE);
    rst(6'h20);
    ws(JLSYNC_ST_CGS);
  endtask
  task tally_and_finish();
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    rst(6'h08);
    t_link();
    t_src();
    tally_and_finish();
  end
  initial
  begin
    #20000 errors++;
    tally_and_finish();
  end
endmodule // jlsync_ctrl_tb_top

// file: sim/jlsync_rx_model.sv
`timescale 1ns/100ps
module jlsync_rx_model
(
  input  wire logic i_clk_sys, i_req, i_cgs_active,
  output logic      o_sync_n
);
  logic seen_reg = 1'h0;
  initial o_sync_n = 1'h1;
  always @(posedge i_clk_sys)
  begin
    seen_reg <= i_req && (seen_reg || i_cgs_active);
    o_sync_n <= !i_req || seen_reg;
  end
endmodule // jlsync_rx_model
